/* wpc_defines.svh */
// Notes on behaviour
// - One unit per output: eight exponential, one high-pass, one bounce, one FIR stage.
// - Chain enable low bypasses every stage; input samples go straight out.
// - Each stage has its own enable; only enabled stages change samples.
// - Enabled chain delays samples by a base of nine filter clock cycles.
// - Filter logic runs on a clock at one eighth of the sample rate.
// - A stage adds its fixed latency only while enabled; total follows configuration.
// - Overflow is flagged when an output reaches the converter maximum or minimum.
// - Each stage shows a live overflow flag while overflow happens now.
// - Each stage keeps a sticky overflow flag after the overflow ends.
// - One status clear command clears the sticky overflow flags of all stages together.
// - The FIR stage convolves with a programmable kernel spanning 30 ns.
// - Clear value 1 then zero playback resets history; value 0 keeps integrating.
// - Outputs saturate at converter full scale instead of wrapping.
// - Clear follows the next playback: whole playback, start, end, or both.
// - An enabled high-pass stage adds twelve filter clock cycles.
// - Each enabled exponential stage adds eleven filter clock cycles.
// - An enabled bounce stage adds four filter clock cycles.
`ifndef WPC_DEFINES_SVH
`define WPC_DEFINES_SVH

`define WPC_LANES      8
`define WPC_SW         16
`define WPC_NUM_EXP    8
`define WPC_NUM_STG    11
`define WPC_STG_HP     8
`define WPC_STG_BNC    9
`define WPC_BASE_LAT   9
`define WPC_EXP_LAT    11
`define WPC_HP_LAT     12
`define WPC_BNC_LAT    4
`define WPC_FIR_LAT    3
`define WPC_SAMPLE_MHZ 2400
`define WPC_FIR_SPAN_NS 30
`define WPC_FIR_TAPS   ((`WPC_FIR_SPAN_NS * `WPC_SAMPLE_MHZ) / 1000)
`define WPC_COEF_FRAC  15
`define WPC_VMAX       48'sh0000_0000_7fff
`define WPC_VMIN       48'shffff_ffff_8000
`define WPC_FIFO_DEPTH 32

`endif

/* wpc_pkg.sv */
package wpc_pkg;

  typedef enum logic [1:0] {
    WPC_CLR_LEVEL = 2'h0,
    WPC_CLR_RISE  = 2'h1,
    WPC_CLR_FALL  = 2'h2,
    WPC_CLR_BOTH  = 2'h3
  } wpc_clr_mode_t;

  typedef enum logic [1:0] {
    WPC_CS_IDLE   = 2'h0,
    WPC_CS_ARMED  = 2'h1,
    WPC_CS_ACTIVE = 2'h2
  } wpc_clr_state_t;

  typedef enum logic [1:0] {
    WPC_K_EXP = 2'h0,
    WPC_K_HP  = 2'h1,
    WPC_K_BNC = 2'h2,
    WPC_K_FIR = 2'h3
  } wpc_kind_t;

endpackage

/* wpc_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module wpc_fifo #(
  parameter int W     = 128,
  parameter int DEPTH = 32
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  // Filling side
  input  wire logic         in_valid,
  output var  logic         in_ready,
  input  wire logic [W-1:0] in_data,
  // Draining side
  output var  logic         out_valid,
  input  wire logic         out_ready,
  output var  logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [W-1:0] next_mem [DEPTH];
  logic [AW-1:0] wr, rd, next_wr, next_rd;
  logic [AW:0]   cnt, next_cnt;
  logic          next_in_ready, next_out_valid;
  logic [W-1:0]  next_out_data;
  logic          push, pop;

  // The head word sits in its own register so the outputs come from flops.
  always_comb begin
    push           = in_valid && in_ready;
    pop            = (!out_valid || out_ready) && (cnt != '0);
    next_mem       = mem;
    next_wr        = wr;
    next_rd        = rd;
    next_out_valid = out_valid;
    next_out_data  = out_data;
    if (push) begin
      next_mem[wr] = in_data;
      next_wr      = wr + 1'b1;
    end
    if (pop) begin
      next_out_data  = mem[rd];
      next_out_valid = 1'b1;
      next_rd        = rd + 1'b1;
    end else if (out_ready) begin
      next_out_valid = 1'b0;
    end
    next_cnt      = cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    next_in_ready = (next_cnt != DEPTH[AW:0]);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr        <= '0;
      rd        <= '0;
      cnt       <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
      out_data  <= '0;
      for (int k = 0; k < DEPTH; k++) begin
        mem[k] <= '0;
      end
    end else begin
      wr        <= next_wr;
      rd        <= next_rd;
      cnt       <= next_cnt;
      in_ready  <= next_in_ready;
      out_valid <= next_out_valid;
      out_data  <= next_out_data;
      mem       <= next_mem;
    end
  end

  a_fifo_count: assert property (@(posedge clk) disable iff (!nrst)
    push && !pop |=> cnt == $past(cnt) + 1'b1)
    else $error("fifo count did not grow on a lone push");
  a_fifo_full: assert property (@(posedge clk) disable iff (!nrst)
    cnt == DEPTH[AW:0] |-> !in_ready)
    else $error("fifo accepts data while full");

endmodule
`default_nettype wire

/* wpc_chain.sv */
`timescale 1ns/1ps
`default_nettype none
`include "wpc_defines.svh"
module wpc_chain
  import wpc_pkg::*;
#(
  parameter int LANES      = `WPC_LANES,
  parameter int SW         = `WPC_SW,
  parameter int TAPS       = `WPC_FIR_TAPS,
  parameter int FIR_LAT    = `WPC_FIR_LAT,
  parameter int FIFO_DEPTH = `WPC_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                  CLK,
  input  wire logic                  NRST,
  // Samples from the waveform generator
  input  wire logic                  IN_VALID,
  output var  logic                  IN_READY,
  input  wire logic                  IN_PLAY,
  input  wire logic [LANES*SW-1:0]   IN_DATA,
  // Samples to the converter
  output var  logic                  OUT_VALID,
  input  wire logic                  OUT_READY,
  output var  logic [LANES*SW-1:0]   OUT_DATA,
  // Configuration
  input  wire logic                  CHAIN_EN,
  input  wire logic [`WPC_NUM_STG-1:0] FILTER_EN,
  input  wire logic signed [15:0]    COEF_A [`WPC_NUM_STG],
  input  wire logic [15:0]           COEF_B [`WPC_NUM_STG],
  input  wire logic signed [15:0]    FIR_COEF [TAPS],
  input  wire logic [1:0]            CLEAR_MODE,
  // Sequencer filter clear instruction
  input  wire logic                  CLEAR_INSTR_VALID,
  input  wire logic                  CLEAR_INSTR_VALUE,
  // Status
  input  wire logic                  STATUS_CLEAR,
  output var  logic [`WPC_NUM_STG-1:0] OVF_LIVE,
  output var  logic [`WPC_NUM_STG-1:0] OVF_STICKY,
  output var  logic [7:0]            LATENCY
);
  localparam int NSTG = `WPC_NUM_STG;
  localparam int BASE = `WPC_BASE_LAT;
  localparam int DW   = LANES * SW;
  // Word layout: valid, playback flag, clear mark, then the sample lanes.
  localparam int W    = DW + 3;

  logic             step;
  logic [4:0]       run_cnt, next_run_cnt;
  logic [W-1:0]     c_in;
  logic [W-1:0]     sin [NSTG];
  logic [W-1:0]     sout [NSTG];
  logic [NSTG-1:0]  ovf_now;
  logic [W-1:0]     chain_out;

  // ---------------------------------------------------------------------
  // Clear sequencing
  // ---------------------------------------------------------------------
  wpc_clr_state_t cs, next_cs;
  logic           prev_play, next_prev_play;
  logic           clr_bit;

  // The mark rides with the samples, so every stage clears on the same
  // sample no matter how much latency lies in front of it.
  always_comb begin
    logic rise;
    logic fall;
    logic lvl;
    logic at_start;
    logic at_end;
    rise           = 1'b0;
    fall           = 1'b0;
    clr_bit        = 1'b0;
    next_cs        = cs;
    next_prev_play = prev_play;
    lvl      = (wpc_clr_mode_t'(CLEAR_MODE) == WPC_CLR_LEVEL);
    at_start = lvl || (wpc_clr_mode_t'(CLEAR_MODE) == WPC_CLR_RISE)
                   || (wpc_clr_mode_t'(CLEAR_MODE) == WPC_CLR_BOTH);
    at_end   = (wpc_clr_mode_t'(CLEAR_MODE) == WPC_CLR_FALL)
            || (wpc_clr_mode_t'(CLEAR_MODE) == WPC_CLR_BOTH);
    if (step && IN_VALID) begin
      rise           = IN_PLAY && !prev_play;
      fall           = !IN_PLAY && prev_play;
      next_prev_play = IN_PLAY;
      case (cs)
        WPC_CS_ARMED: begin
          if (rise) begin
            clr_bit = at_start;
            next_cs = WPC_CS_ACTIVE;
          end
        end
        WPC_CS_ACTIVE: begin
          if (fall) begin
            clr_bit = at_end;
            next_cs = WPC_CS_IDLE;
          end else begin
            clr_bit = lvl;
          end
        end
        default: next_cs = WPC_CS_IDLE;
      endcase
    end
    if (CLEAR_INSTR_VALID) begin
      next_cs = CLEAR_INSTR_VALUE ? WPC_CS_ARMED : WPC_CS_IDLE;
    end
    c_in = {IN_VALID, IN_PLAY, clr_bit, IN_DATA};
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cs        <= WPC_CS_IDLE;
      prev_play <= 1'b0;
    end else begin
      cs        <= next_cs;
      prev_play <= next_prev_play;
    end
  end

  // ---------------------------------------------------------------------
  // Base latency and stage chain
  // ---------------------------------------------------------------------
  logic [W-1:0] base_q [BASE];
  logic [W-1:0] next_base [BASE];

  always_comb begin
    next_base[0] = step ? c_in : base_q[0];
    for (int k = 1; k < BASE; k++) begin
      next_base[k] = step ? base_q[k-1] : base_q[k];
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      for (int k = 0; k < BASE; k++) begin
        base_q[k] <= '0;
      end
    end else begin
      base_q <= next_base;
    end
  end

  for (genvar i = 0; i < NSTG; i++) begin : g_stg
    localparam wpc_kind_t KIND = (i < `WPC_NUM_EXP) ? WPC_K_EXP :
                                 (i == `WPC_STG_HP) ? WPC_K_HP :
                                 (i == `WPC_STG_BNC) ? WPC_K_BNC : WPC_K_FIR;
    localparam int LAT = (KIND == WPC_K_EXP) ? `WPC_EXP_LAT :
                         (KIND == WPC_K_HP) ? `WPC_HP_LAT :
                         (KIND == WPC_K_BNC) ? `WPC_BNC_LAT : FIR_LAT;

    logic [W-1:0]          dl [LAT];
    logic [W-1:0]          next_dl [LAT];
    logic signed [31:0]    acc, next_acc, st_fin;
    logic signed [SW-1:0]  hist [TAPS];
    logic signed [SW-1:0]  next_hist [TAPS];
    logic [DW-1:0]         y;
    logic                  ov, adv;

    if (i == 0) begin : g_first
      assign sin[i] = base_q[BASE-1];
    end else begin : g_next
      assign sin[i] = sout[i-1];
    end

    // Lanes are worked oldest first so the recursive state sees every
    // sample in order within one filter clock.
    always_comb begin
      logic signed [SW-1:0] win [TAPS+LANES];
      logic signed [31:0]   st;
      logic signed [47:0]   v;
      int                   d;
      for (int k = 0; k < TAPS; k++) begin
        win[k] = hist[k];
      end
      for (int l = 0; l < LANES; l++) begin
        win[TAPS+l] = sin[i][l*SW +: SW];
      end
      st  = sin[i][W-3] ? 32'sh0000_0000 : acc;
      ov  = 1'b0;
      y   = '0;
      v   = '0;
      d   = int'(COEF_B[i][5:0]) + 1;
      adv = step && sin[i][W-1];
      for (int l = 0; l < LANES; l++) begin
        case (KIND)
          WPC_K_EXP: begin
            st = st + ((win[TAPS+l] - st) >>> COEF_B[i][3:0]);
            v  = win[TAPS+l] + ((COEF_A[i] * (win[TAPS+l] - st)) >>> `WPC_COEF_FRAC);
          end
          WPC_K_HP: begin
            st = st + win[TAPS+l];
            v  = win[TAPS+l] + ((COEF_A[i] * st) >>> `WPC_COEF_FRAC);
          end
          WPC_K_BNC: begin
            v = win[TAPS+l] + ((COEF_A[i] * win[TAPS+l-d]) >>> `WPC_COEF_FRAC);
          end
          default: begin
            v = '0;
            for (int t = 0; t < TAPS; t++) begin
              v = v + FIR_COEF[t] * win[TAPS+l-t];
            end
            v = v >>> `WPC_COEF_FRAC;
          end
        endcase
        if (v >= `WPC_VMAX) begin
          y[l*SW +: SW] = SW'(`WPC_VMAX);
          ov            = 1'b1;
        end else if (v <= `WPC_VMIN) begin
          y[l*SW +: SW] = SW'(`WPC_VMIN);
          ov            = 1'b1;
        end else begin
          y[l*SW +: SW] = v[SW-1:0];
        end
      end
      st_fin = st;
    end

    always_comb begin
      next_acc  = acc;
      next_hist = hist;
      if (adv) begin
        next_acc = FILTER_EN[i] ? st_fin : (sin[i][W-3] ? 32'sh0000_0000 : acc);
        for (int k = 0; k < TAPS - LANES; k++) begin
          next_hist[k] = hist[k+LANES];
        end
        for (int l = 0; l < LANES; l++) begin
          next_hist[TAPS-LANES+l] = sin[i][l*SW +: SW];
        end
      end
      next_dl[0] = step ? {sin[i][W-1:W-3], y} : dl[0];
      for (int k = 1; k < LAT; k++) begin
        next_dl[k] = step ? dl[k-1] : dl[k];
      end
    end

    always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
        acc <= '0;
        for (int k = 0; k < TAPS; k++) begin
          hist[k] <= '0;
        end
        for (int k = 0; k < LAT; k++) begin
          dl[k] <= '0;
        end
      end else begin
        acc  <= next_acc;
        hist <= next_hist;
        dl   <= next_dl;
      end
    end

    assign ovf_now[i] = adv && FILTER_EN[i] && ov;
    assign sout[i]    = FILTER_EN[i] ? dl[LAT-1] : sin[i];

    a_stage_delay: assert property (@(posedge CLK) disable iff (!NRST)
      run_cnt >= 5'(LAT) && FILTER_EN[i] |-> sout[i][W-1:W-3] == $past(sin[i][W-1:W-3], LAT))
      else $error("stage latency differs from its fixed figure");
    a_clear_zero: assert property (@(posedge CLK) disable iff (!NRST)
      adv && sin[i][W-3] && sin[i][DW-1:0] == '0 |=> acc == 32'sh0000_0000)
      else $error("clear with zero samples left filter history");
  end

  assign chain_out = CHAIN_EN ? sout[NSTG-1] : c_in;

  // ---------------------------------------------------------------------
  // Status and latency report
  // ---------------------------------------------------------------------
  logic [NSTG-1:0] next_live, next_sticky;
  logic [7:0]      next_latency;
  logic [NSTG-1:0] prev_en;
  logic            prev_chain;

  // A new overflow in the clearing cycle survives the clear.
  always_comb begin
    next_live    = step ? ovf_now : OVF_LIVE;
    next_sticky  = ovf_now | (OVF_STICKY & {NSTG{!STATUS_CLEAR}});
    next_latency = 8'(BASE);
    for (int k = 0; k < NSTG; k++) begin
      if (FILTER_EN[k]) begin
        next_latency = next_latency + ((k < `WPC_NUM_EXP) ? 8'(`WPC_EXP_LAT) :
                       (k == `WPC_STG_HP) ? 8'(`WPC_HP_LAT) :
                       (k == `WPC_STG_BNC) ? 8'(`WPC_BNC_LAT) : 8'(FIR_LAT));
      end
    end
    if (!CHAIN_EN) begin
      next_latency = 8'h00;
    end
    next_run_cnt = '0;
    if (step && FILTER_EN == prev_en && CHAIN_EN == prev_chain) begin
      next_run_cnt = (run_cnt == 5'h1f) ? run_cnt : run_cnt + 5'h01;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      OVF_LIVE   <= '0;
      OVF_STICKY <= '0;
      LATENCY    <= 8'h00;
      run_cnt    <= '0;
      prev_en    <= '0;
      prev_chain <= 1'b0;
    end else begin
      OVF_LIVE   <= next_live;
      OVF_STICKY <= next_sticky;
      LATENCY    <= next_latency;
      run_cnt    <= next_run_cnt;
      prev_en    <= FILTER_EN;
      prev_chain <= CHAIN_EN;
    end
  end

  // The chain moves only when the output buffer has room, so a stalled
  // converter holds every stage instead of dropping samples.
  wpc_fifo #(
    .W     (DW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK),
    .nrst      (NRST),
    .in_valid  (step && chain_out[W-1]),
    .in_ready  (step),
    .in_data   (chain_out[DW-1:0]),
    .out_valid (OUT_VALID),
    .out_ready (OUT_READY),
    .out_data  (OUT_DATA)
  );
  assign IN_READY = step;

  a_base_latency: assert property (@(posedge CLK) disable iff (!NRST)
    CHAIN_EN && run_cnt >= 5'd9 |-> base_q[BASE-1][W-1:W-3] == $past(c_in[W-1:W-3], 9))
    else $error("base delay is not nine cycles");
  a_chain_bypass: assert property (@(posedge CLK) disable iff (!NRST)
    !CHAIN_EN && step && IN_VALID |-> chain_out[DW-1:0] == IN_DATA)
    else $error("bypassed chain altered samples");
  a_ovf_live: assert property (@(posedge CLK) disable iff (!NRST)
    ovf_now != '0 |=> (OVF_LIVE & $past(ovf_now)) == $past(ovf_now)
                      && (OVF_STICKY & $past(ovf_now)) == $past(ovf_now))
    else $error("overflow not shown on live and sticky flags");
  a_sticky_hold: assert property (@(posedge CLK) disable iff (!NRST)
    !STATUS_CLEAR |=> (OVF_STICKY & $past(OVF_STICKY)) == $past(OVF_STICKY))
    else $error("sticky overflow dropped without a clear");
  a_status_clear: assert property (@(posedge CLK) disable iff (!NRST)
    STATUS_CLEAR && ovf_now == '0 |=> OVF_STICKY == '0)
    else $error("status clear left a sticky flag set");
  a_latency_base: assert property (@(posedge CLK) disable iff (!NRST)
    CHAIN_EN && FILTER_EN == '0 |=> LATENCY == 8'h09)
    else $error("reported latency with no stage enabled is not nine");

endmodule
`default_nettype wire

/* wpc_dac_model.sv */
`timescale 1ns/1ps
`default_nettype none
module wpc_dac_model #(
  parameter int W = 128
) (
  // Clock and test control
  input  wire logic         clk,
  input  wire logic         stall,
  // Word stream from the chain
  input  wire logic         valid,
  input  wire logic [W-1:0] data,
  output var  logic         ready
);
  // Words taken by the converter, oldest first.
  logic [W-1:0] got [$];

  // Ready moves only on the falling edge, so it is settled at every sampling edge.
  initial begin
    ready = 1'b1;
    forever @(negedge clk) ready <= !stall;
  end

  always @(posedge clk) begin
    if (valid && ready) begin
      got.push_back(data);
    end
  end
endmodule
`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "wpc_defines.svh"
module testbench;
  import wpc_pkg::*;
  localparam int TAPS = `WPC_FIR_TAPS;
  localparam int NS   = `WPC_NUM_STG;
  // Bit 11 is the chain enable, bits 10:0 the stage enables.
  localparam logic [11:0] LTAB [9] = '{12'h800, 12'h801, 12'h8ff, 12'h900, 12'ha00,
                                       12'hc00, 12'hfff, 12'h7ff, 12'h000};

  logic                clk = 1'b0;
  logic                nrst, in_valid, in_ready, in_play, out_valid, out_ready;
  logic                chain_en, ci_valid, ci_value, st_clr, stall;
  logic [127:0]        in_data, out_data;
  logic [NS-1:0]       fen, ovf_live, ovf_sticky;
  logic signed [15:0]  coef_a [NS];
  logic [15:0]         coef_b [NS];
  logic signed [15:0]  fir_coef [TAPS];
  logic [1:0]          clr_mode;
  logic [7:0]          latency;
  int                  miscompares = 0;
  int                  total_checks = 0;

  always #2.5 clk = ~clk;

  wpc_chain u_dut (
    .CLK(clk), .NRST(nrst), .IN_VALID(in_valid), .IN_READY(in_ready), .IN_PLAY(in_play),
    .IN_DATA(in_data), .OUT_VALID(out_valid), .OUT_READY(out_ready), .OUT_DATA(out_data),
    .CHAIN_EN(chain_en), .FILTER_EN(fen), .COEF_A(coef_a), .COEF_B(coef_b),
    .FIR_COEF(fir_coef), .CLEAR_MODE(clr_mode), .CLEAR_INSTR_VALID(ci_valid),
    .CLEAR_INSTR_VALUE(ci_value), .STATUS_CLEAR(st_clr), .OVF_LIVE(ovf_live),
    .OVF_STICKY(ovf_sticky), .LATENCY(latency)
  );

  wpc_dac_model u_dac (
    .clk(clk), .stall(stall), .valid(out_valid), .data(out_data), .ready(out_ready)
  );

  // ----------------------------------------------------------------
  // Checking and driving helpers
  // ----------------------------------------------------------------
  task automatic results();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk_word(string what, logic [127:0] e, logic [127:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic chk_num(string what, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %0d seen %0d", what, e, g);
    end
  endtask

  task automatic give_up(string what);
    miscompares++;
    $display("mismatch %s expected done seen timeout", what);
    results();
  endtask

  // Holds the word from a falling edge until a rising edge with room has taken it.
  task automatic put(logic [127:0] w, logic play);
    int i;
    in_valid = 1'b1;
    in_data = w;
    in_play = play;
    for (i = 0; i < 500 && in_ready !== 1'b1; i++) @(negedge clk);
    if (i == 500) give_up("input ready");
    @(negedge clk);
  endtask

  task automatic wait_n(int n);
    int i;
    for (i = 0; i < 2000 && u_dac.got.size() < n; i++) @(negedge clk);
    if (i == 2000) give_up("output count");
  endtask

  task automatic cfg(logic ce, logic [NS-1:0] fe);
    in_valid = 1'b0;
    chain_en = ce;
    fen = fe;
    // Words left in a stage's delay line surface when that stage is switched on,
    // so the longest path is flushed before the words of a scenario are counted.
    repeat (140) @(negedge clk);
    u_dac.got.delete();
  endtask

  function automatic logic [31:0] exp_lat(logic [11:0] c);
    if (!c[11]) return 32'h0000_0000;
    return `WPC_BASE_LAT + `WPC_EXP_LAT * $countones(c[7:0]) + `WPC_HP_LAT * c[8]
         + `WPC_BNC_LAT * c[9] + `WPC_FIR_LAT * c[10];
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic sc_latency();
    logic [31:0]  e;
    logic [127:0] w;
    int           k;
    foreach (LTAB[t]) begin
      cfg(LTAB[t][11], LTAB[t][10:0]);
      e = exp_lat(LTAB[t]);
      w = {8{16'h0a50 + 16'(t)}};
      chk_num("latency port", e, {24'h00_0000, latency});
      put(w, 1'b0);
      in_valid = 1'b0;
      k = 0;
      while (out_valid !== 1'b1 && k < 400) begin
        @(negedge clk);
        k++;
      end
      // The count starts after the taking edge, so the buffer adds one cycle.
      chk_num("cycles to output", e + 32'd1, k);
      wait_n(1);
      if (!LTAB[t][11] || LTAB[t][10:0] == '0) begin
        chk_word("unfiltered word", w, u_dac.got[0]);
      end
    end
  endtask

  task automatic sc_overflow();
    logic [15:0] v [2] = '{16'h7fff, 16'h8000};
    logic        seen;
    coef_a[`WPC_STG_BNC] = 16'sh7fff;
    cfg(1'b1, 11'h200);
    foreach (v[j]) begin
      u_dac.got.delete();
      put({8{v[j]}}, 1'b0);
      put({8{v[j]}}, 1'b0);
      in_valid = 1'b0;
      seen = 1'b0;
      repeat (40) begin
        @(negedge clk);
        seen = seen | (ovf_live[`WPC_STG_BNC] === 1'b1);
      end
      wait_n(2);
      chk_word("clamped word", {8{v[j]}}, u_dac.got[1]);
      chk_num("live flag seen", 32'd1, {31'd0, seen});
      chk_num("sticky flag", 32'd1, {31'd0, ovf_sticky[`WPC_STG_BNC]});
      st_clr = 1'b1;
      @(negedge clk);
      st_clr = 1'b0;
      @(negedge clk);
      chk_num("sticky after clear", 32'd0, {21'd0, ovf_sticky});
    end
    coef_a[`WPC_STG_BNC] = 16'sh0000;
  endtask

  task automatic sc_buffer();
    int n;
    cfg(1'b0, 11'h000);
    stall = 1'b1;
    repeat (2) @(negedge clk);
    for (n = 0; n < 60 && in_ready === 1'b1; n++) put({8{n[15:0]}}, 1'b0);
    in_valid = 1'b0;
    chk_num("full buffer refuses", 32'd0, {31'd0, in_ready});
    repeat (5) @(negedge clk);
    chk_word("head word held", {8{16'h0000}}, out_data);
    chk_num("nothing taken in stall", 32'd0, u_dac.got.size());
    stall = 1'b0;
    wait_n(n);
    repeat (5) @(negedge clk);
    chk_num("words drained", n, u_dac.got.size());
    foreach (u_dac.got[i]) chk_word("drained word", {8{i[15:0]}}, u_dac.got[i]);
    chk_num("empty after drain", 32'd0, {31'd0, out_valid});
  endtask

  // History is built with nonzero words, then an armed clear must leave zero words at zero.
  task automatic sc_clear();
    coef_a[`WPC_STG_HP] = 16'sh4000;
    cfg(1'b1, 11'h100);
    for (int m = 0; m < 4; m++) begin
      clr_mode = m[1:0];
      u_dac.got.delete();
      repeat (3) put({8{16'h1000}}, 1'b0);
      in_valid = 1'b0;
      ci_valid = 1'b1;
      ci_value = 1'b1;
      @(negedge clk);
      ci_valid = 1'b0;
      put('0, 1'b1);
      put('0, 1'b1);
      put('0, 1'b0);
      in_valid = 1'b0;
      wait_n(6);
      for (int b = 3; b < 6; b++) begin
        if (m != 2 || b == 5) chk_word("word after clear", '0, u_dac.got[b]);
      end
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    {in_valid, in_play, chain_en, ci_valid, ci_value, st_clr, stall} = '0;
    in_data = '0;
    fen = '0;
    clr_mode = 2'h0;
    foreach (coef_a[i]) coef_a[i] = 16'sh0000;
    foreach (coef_b[i]) coef_b[i] = 16'h0000;
    foreach (fir_coef[i]) fir_coef[i] = 16'sh0000;
    repeat (5) @(negedge clk);
    chk_num("ready in reset", 32'd1, {31'd0, in_ready});
    chk_num("valid in reset", 32'd0, {31'd0, out_valid});
    chk_num("sticky in reset", 32'd0, {21'd0, ovf_sticky});
    nrst = 1'b1;
    @(negedge clk);
    sc_latency();
    sc_overflow();
    sc_buffer();
    sc_clear();
    results();
  end
endmodule
`default_nettype wire
